// ==== design/frt_timer.sv ====
// free-running 16-bit counter and 12-bit interval timer with an apb slave
`timescale 1ns/1ps

module frt_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [frt_pkg::ADDR_W-1:0] paddr,
	input wire logic [frt_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [frt_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tick_irq,
	output logic wrap_irq,
	output logic interval_irq
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [frt_pkg::ACC_W-1:0] acc_q;
	logic [frt_pkg::ACC_W-1:0] acc_d;
	logic tmr_en_q;
	logic [frt_pkg::FREE_W-1:0] free_q;
	logic [frt_pkg::FREE_W-1:0] free_inc;
	logic [7:0] free_hold_q;
	logic [7:0] load_low_q;
	logic [frt_pkg::INT_W-1:0] int_q;
	logic [frt_pkg::NIB_W-1:0] int_hold_q;
	logic [7:0] rld_low_q;
	logic [frt_pkg::NIB_W-1:0] rld_high_q;
	logic [frt_pkg::DATA_W-1:0] rdata_q;
	logic err_q;
	logic setup_rd;
	logic acc_wr;
	logic lane0;
	logic hit;
	logic [7:0] rd_byte;
	logic free_load;
	logic free_low_wr;
	logic rld_low_wr;
	logic rld_high_wr;
	logic free_low_rd;
	logic int_low_rd;
	logic ro_hit;

	// ------------------------------------------------------------------
	// bus phase decode
	// ------------------------------------------------------------------
	// side effects of reads happen in the setup cycle, writes at the access edge
	assign setup_rd = psel & ~penable & ~pwrite;
	assign acc_wr = psel & penable & pwrite & ~err_q;
	assign lane0 = pstrb[0];
	assign pready = 1'b1;
	assign pslverr = psel & penable & err_q;
	assign prdata = rdata_q;

	// ------------------------------------------------------------------
	// register strobes
	// ------------------------------------------------------------------
	// writes need byte lane 0; a write with lane 0 off is dropped silently
	assign free_load = acc_wr & lane0 & (paddr == frt_pkg::ADDR_FREE_HIGH);
	assign free_low_wr = acc_wr & lane0 & (paddr == frt_pkg::ADDR_FREE_LOW);
	assign rld_low_wr = acc_wr & lane0 & (paddr == frt_pkg::ADDR_INT_RLD_LOW);
	assign rld_high_wr = acc_wr & lane0 & (paddr == frt_pkg::ADDR_INT_RLD_HIGH);
	// snapshots ride on the setup cycle of a read, the cycle prdata latches
	assign free_low_rd = setup_rd & (paddr == frt_pkg::ADDR_FREE_LOW);
	assign int_low_rd = setup_rd & (paddr == frt_pkg::ADDR_INT_CNT_LOW);
	// the interval count registers are read-only
	assign ro_hit = (paddr == frt_pkg::ADDR_INT_CNT_LOW)
		| (paddr == frt_pkg::ADDR_INT_CNT_HIGH);

	// ------------------------------------------------------------------
	// timer-rate enable
	// ------------------------------------------------------------------
	// fractional divider: 4 enables per 25 pclk cycles gives exactly 4 MHz,
	// with a jitter of one pclk period on each edge
	always_comb
	begin
		acc_d = frt_pkg::ACC_W'(acc_q + frt_pkg::ACC_STEP);
		if (acc_d >= frt_pkg::ACC_MOD)
		begin
			acc_d = frt_pkg::ACC_W'(acc_d - frt_pkg::ACC_MOD);
		end
	end

	// enable pulse when the accumulator wraps
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_q <= frt_pkg::ACC_RST;
			tmr_en_q <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			tmr_en_q <= (frt_pkg::ACC_W'(acc_q + frt_pkg::ACC_STEP) >= frt_pkg::ACC_MOD);
		end
	end

	// ------------------------------------------------------------------
	// free-running counter
	// ------------------------------------------------------------------
	assign free_inc = frt_pkg::FREE_W'(free_q + 16'h0001);

	// a load wins over a count in the same cycle; the bus only reaches the
	// counter on pclk edges, so no crossing is needed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			free_q <= frt_pkg::FREE_RST;
		end
		else if (free_load)
		begin
			free_q <= {pwdata[7:0], load_low_q};
		end
		else if (tmr_en_q)
		begin
			free_q <= free_inc;
		end
	end

	// low byte of a load waits here until the high byte arrives
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			load_low_q <= frt_pkg::BYTE_RST;
		end
		else if (free_low_wr)
		begin
			load_low_q <= pwdata[7:0];
		end
	end

	// high byte snapshot taken with the low byte read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			free_hold_q <= frt_pkg::BYTE_RST;
		end
		else if (free_low_rd)
		begin
			free_hold_q <= free_q[15:8];
		end
	end

	// ------------------------------------------------------------------
	// tick and wrap requests
	// ------------------------------------------------------------------
	// one-cycle pulses; a load beats the count, so the cycle of a load
	// never raises a request (same condition as the load itself)
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_irq <= 1'b0;
		end
		else
		begin
			tick_irq <= tmr_en_q && !free_load
				&& free_inc[11:0] == frt_pkg::TICK_MASK_ZERO;
		end
	end

	// wrap always coincides with a tick, since the low 12 bits wrap too
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wrap_irq <= 1'b0;
		end
		else
		begin
			wrap_irq <= tmr_en_q && !free_load
				&& free_q == frt_pkg::FREE_MAX;
		end
	end

	// ------------------------------------------------------------------
	// interval timer
	// ------------------------------------------------------------------
	// down counter; at zero it reloads and raises its request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_q <= frt_pkg::INT_RST;
			interval_irq <= 1'b0;
		end
		else
		begin
			interval_irq <= 1'b0;
			if (tmr_en_q)
			begin
				if (int_q == frt_pkg::INT_TERM)
				begin
					int_q <= {rld_high_q, rld_low_q};
					interval_irq <= 1'b1;
				end
				else
				begin
					int_q <= frt_pkg::INT_W'(int_q - 12'h001);
				end
			end
		end
	end

	// upper nibble snapshot with the interval low byte read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_hold_q <= frt_pkg::NIB_RST;
		end
		else if (int_low_rd)
		begin
			int_hold_q <= int_q[11:8];
		end
	end

	// reload low byte; takes effect at the next terminal count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rld_low_q <= frt_pkg::BYTE_RST;
		end
		else if (rld_low_wr)
		begin
			rld_low_q <= pwdata[7:0];
		end
	end

	// reload upper nibble; bits 7:4 of the write are dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rld_high_q <= frt_pkg::NIB_RST;
		end
		else if (rld_high_wr)
		begin
			rld_high_q <= pwdata[3:0];
		end
	end

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	always_comb
	begin
		hit = 1'b1;
		rd_byte = frt_pkg::BYTE_RST;
		unique case (paddr)
			frt_pkg::ADDR_FREE_LOW: rd_byte = free_q[7:0];
			frt_pkg::ADDR_FREE_HIGH: rd_byte = free_hold_q;
			frt_pkg::ADDR_INT_CNT_LOW: rd_byte = int_q[7:0];
			frt_pkg::ADDR_INT_CNT_HIGH: rd_byte = {4'h0, int_hold_q};
			frt_pkg::ADDR_INT_RLD_LOW: rd_byte = rld_low_q;
			frt_pkg::ADDR_INT_RLD_HIGH: rd_byte = {4'h0, rld_high_q};
			default: hit = 1'b0;
		endcase
	end

	// read data latched in setup and held until the next setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_q <= 32'h00000000;
		end
		else if (psel && !penable)
		begin
			rdata_q <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
		end
	end

	// error flag latched in setup; a write to the read-only interval count
	// is refused, so a stray store cannot disturb the running timer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			err_q <= 1'b0;
		end
		else if (psel && !penable)
		begin
			err_q <= !hit || (pwrite && ro_hit);
		end
	end

endmodule : frt_timer

// ==== design/frt_pkg.sv ====
// constants shared by the free-running and interval timer block
package frt_pkg;

	// ------------------------------------------------------------------
	// bus and register map
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	// printed offsets are register indices; byte address is four times that
	localparam logic [7:0] IDX_FREE_LOW = 8'h20;
	localparam logic [7:0] IDX_FREE_HIGH = 8'h21;
	localparam logic [7:0] IDX_INT_CNT_LOW = 8'h26;
	localparam logic [7:0] IDX_INT_CNT_HIGH = 8'h27;
	localparam logic [7:0] IDX_INT_RLD_LOW = 8'h28;
	localparam logic [7:0] IDX_INT_RLD_HIGH = 8'h29;
	localparam logic [ADDR_W-1:0] ADDR_FREE_LOW = {2'h0, IDX_FREE_LOW, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_FREE_HIGH = {2'h0, IDX_FREE_HIGH, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_INT_CNT_LOW = {2'h0, IDX_INT_CNT_LOW, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_INT_CNT_HIGH = {2'h0, IDX_INT_CNT_HIGH, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_INT_RLD_LOW = {2'h0, IDX_INT_RLD_LOW, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_INT_RLD_HIGH = {2'h0, IDX_INT_RLD_HIGH, 2'h0};

	// ------------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------------
	localparam int unsigned FREE_W = 16;
	localparam int unsigned INT_W = 12;
	localparam int unsigned NIB_W = 4;
	localparam logic [FREE_W-1:0] FREE_RST = 16'h0000;
	localparam logic [INT_W-1:0] INT_RST = 12'h000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
	localparam logic [FREE_W-1:0] FREE_MAX = 16'hFFFF;
	localparam logic [INT_W-1:0] INT_TERM = 12'h000;
	// tick event when low 12 bits of the counter wrap to zero
	localparam logic [11:0] TICK_MASK_ZERO = 12'h000;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int unsigned PCLK_MHZ = 25;
	localparam int unsigned TMR_CLK_MHZ = 4;
	localparam int unsigned TICK_US = 1024;
	localparam int unsigned TICK_COUNTS = TICK_US * TMR_CLK_MHZ;
	localparam int unsigned ACC_W = 5;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TMR_CLK_MHZ);
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(PCLK_MHZ);
	localparam logic [ACC_W-1:0] ACC_RST = 5'h00;

endpackage : frt_pkg

// ==== verif/frt_timer_sva.sv ====
// checker for the timer block ports
`timescale 1ns/1ps
module frt_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [frt_pkg::ADDR_W-1:0] paddr,
	input wire logic [frt_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tick_irq,
	input wire logic wrap_irq,
	input wire logic interval_irq
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a tick is 4096 timer counts apart, so eight quiet cycles is a loose floor
	a_rsvd_zero: assert property (prdata[31:8] == 24'h000000)
		else $error("upper read data bits set");
	a_tick_gap: assert property (tick_irq |=> !tick_irq [*8])
		else $error("tick pulses too close");
	a_wrap_tick: assert property (wrap_irq |-> tick_irq)
		else $error("wrap without tick");
	a_wrap_pulse: assert property (wrap_irq |=> !wrap_irq)
		else $error("wrap pulse too long");
	a_intv_pulse: assert property (interval_irq |=> !interval_irq)
		else $error("interval pulse too long");
	a_nib_only: assert property (psel && !penable && !pwrite
		&& paddr == frt_pkg::ADDR_INT_CNT_HIGH |=> prdata[7:4] == 4'h0)
		else $error("interval high reserved bits set");
	a_err_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	a_ro_error: assert property (psel && penable && pwrite
		&& paddr == frt_pkg::ADDR_INT_CNT_LOW |-> pslverr)
		else $error("count write not refused");
	c_wrap: cover property (wrap_irq);
	c_intv: cover property (interval_irq);
	c_err: cover property (pslverr);
	c_tick: cover property (tick_irq);
endmodule : frt_chk
bind frt_timer frt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tick_irq(tick_irq), .wrap_irq(wrap_irq), .interval_irq(interval_irq));

// ==== verif/frt_cpu_bfm.sv ====
// processor side apb master model
`timescale 1ns/1ps
module frt_cpu_bfm (
	input wire logic pclk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h000,
	output logic [31:0] pwdata = 32'h00000000,
	output logic [3:0] pstrb = 4'h0
);
	// one transfer, entered just after a rising edge; no wait count assumed
	task xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
		output logic [7:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge, so the next call never reassigns psel in this time step
		@(posedge pclk);
	endtask : xfer
endmodule : frt_cpu_bfm

// ==== verif/tb_free_run_and_interval_timer.sv ====
// testbench for the timer block
`timescale 1ns/1ps
module tb_free_run_and_interval_timer;
	localparam logic [11:0] FL = 12'h080, FH = 12'h084, CL = 12'h098, CH = 12'h09C;
	localparam logic [11:0] RL = 12'h0A0, RH = 12'h0A4;
	logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [7:0] r;
	logic [7:0] s0;
	wire [2:0] irqs;
	int n_mismatch = 0, checked = 0, n;
	frt_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tick_irq(irqs[0]), .wrap_irq(irqs[1]),
		.interval_irq(irqs[2]));
	frt_cpu_bfm u_cpu (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial forever #20 pclk = ~pclk;
	task chk(input string nm, input logic [7:0] s, input logic [7:0] x);
		checked++;
		if (s !== x)
		begin
			n_mismatch++;
			$display("[FAIL] %s exp %h seen %h", nm, x, s);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [7:0] d);
		u_cpu.xfer(1'b1, a, d, 4'hF, r, e);
	endtask : wr
	task rd(input logic [11:0] a);
		u_cpu.xfer(1'b0, a, 8'h00, 4'hF, r, e);
	endtask : rd
	// cycles until the chosen request pulses, bounded
	task wt(input int k);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (irqs[k] !== 1'b1 && n < 2000);
	endtask : wt
	task test_done();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
		begin
			$display("STATUS OK");
		end
		else
		begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	// watchdog; the whole run needs under a thousand cycles
	initial
	begin
		#2000000;
		n_mismatch++;
		test_done();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(RH);
		chk("reload high rst", r, 8'h00);
		rd(FH);
		chk("free high rst", r, 8'h00);
		rd(12'hFFC);
		chk("unmapped err", {7'h0, e}, 8'h01);
		wr(CL, 8'h11);
		chk("count ro err", {7'h0, e}, 8'h01);
		wr(RL, 8'h05);
		wr(RH, 8'hF0);
		u_cpu.xfer(1'b1, RL, 8'h55, 4'hE, r, e);
		rd(RL);
		chk("reload low", r, 8'h05);
		rd(RH);
		chk("reload high", r, 8'h00);
		wt(2);
		wt(2);
		chk("interval period", {7'h0, n >= 36 && n <= 39}, 8'h01);
		rd(CL);
		chk("interval low", {7'h0, r < 8'h06}, 8'h01);
		rd(CH);
		chk("interval high", r, 8'h00);
		// the counter keeps running from reset: a buffered low byte must not
		// show, so the live low byte only moves by a count or so
		rd(FL);
		s0 = r;
		wr(FL, 8'hF0);
		rd(FL);
		chk("low buffered", {7'h0, (r - s0) < 8'h04}, 8'h01);
		wr(FH, 8'h12);
		rd(FL);
		chk("load low", {4'h0, r[7:4]}, 8'h0F);
		rd(FH);
		chk("load high", r, 8'h12);
		repeat (400) @(posedge pclk);
		rd(FH);
		chk("held high", r, 8'h12);
		rd(FL);
		rd(FH);
		chk("live high", r, 8'h13);
		wr(FL, 8'hF8);
		wr(FH, 8'h0F);
		wt(0);
		chk("tick seen", {7'h0, n < 200}, 8'h01);
		wr(FL, 8'hF0);
		wr(FH, 8'hFF);
		wt(1);
		chk("wrap seen", {7'h0, n < 200}, 8'h01);
		// mid-run reset: reload and holding registers return to zero
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(RL);
		chk("reload low after reset", r, 8'h00);
		rd(FH);
		chk("held high after reset", r, 8'h00);
		test_done();
	end
endmodule : tb_free_run_and_interval_timer
